/* analog_input_channel_status.sv */
// status logic of one analog input channel behind an AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "analog_input_channel_status_cfg.svh"

module analog_input_channel_status #(
    parameter int unsigned MS_CYCLES = `CYC_PER_MS
) (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rstn,
    input  wire logic                          i_hsel,
    input  wire logic [31:0]                   i_haddr,
    input  wire logic [1:0]                    i_htrans,
    input  wire logic                          i_hwrite,
    input  wire logic [2:0]                    i_hsize,
    input  wire logic [31:0]                   i_hwdata,
    input  wire logic                          i_hready,
    output logic                               o_hreadyout,
    output logic                               o_hresp,
    output logic [31:0]                        o_hrdata,
    input  wire ain_status_pkg::scan_in_t      i_scan,
    input  wire ain_status_pkg::cal_evt_t      i_cal,
    input  wire logic                          i_conn_open,
    output ain_status_pkg::chan_status_t       o_status,
    output logic [31:0]                        o_data,
    output logic [`STAMP_W-1:0]                o_stamp
);

    // ---------------------------------------------------------------
    // state and helper nets
    // ---------------------------------------------------------------
    ain_status_pkg::state_t st;
    ain_status_pkg::state_t next_st;

    logic                  ms_tick;
    logic                  bus_take;
    logic [`NALARM-1:0]    alarm_act;
    logic [`NALARM-1:0]    unl_edge;
    logic [`NALARM-1:0]    latch_on;
    logic [`NALARM-1:0]    cond;
    logic [`NALARM-1:0]    release_ok;
    logic [32:0]           delta;
    logic [32:0]           delta_mag;
    logic [`STAMP_W-1:0]   dt;
    logic [`STAMP_W-1:0]   dt_eff;
    logic [30:0]           slope_room;
    logic                  slope_over;
    logic [33:0]           upper_rel;
    logic [33:0]           uu_rel;
    logic [33:0]           value_ext;
    logic                  cal_variant;
    logic                  pass_ok;

    // ---------------------------------------------------------------
    // millisecond divider
    // ---------------------------------------------------------------
    // one-cycle tick every millisecond of i_clk_sys
    assign ms_tick = (st.div == `DIV_W'(MS_CYCLES - 1));

    // ---------------------------------------------------------------
    // per-alarm gating and unlatch edges
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `NALARM; g++) begin : g_alarm
            // alarm works only when enabled and not switched off
            assign alarm_act[g] = st.ctrl[`CTRL_EN_LSB + g]
                                & ~st.ctrl[`CTRL_ALARMS_OFF];
            // only the rising edge of the unlatch bit counts
            assign unl_edge[g]  = st.unlatch[g]
                                & ~st.unlatch_prev[g];
            assign latch_on[g]  = st.ctrl[`CTRL_LATCH_LSB + g];
        end
    endgenerate

    // ---------------------------------------------------------------
    // limit and slope conditions
    // ---------------------------------------------------------------
    // thresholds compared in signed fixed point; float compare avoided
    assign value_ext = {{2{st.value[31]}}, st.value};
    assign upper_rel = {{2{st.upper_thr[31]}}, st.upper_thr}
                     - {2'b00, st.deadband};
    assign uu_rel    = {{2{st.uu_thr[31]}}, st.uu_thr}
                     - {2'b00, st.deadband};
    assign cond[`AL_UPPER] = ($signed(st.value) >
                              $signed(st.upper_thr));
    assign cond[`AL_UU]    = ($signed(st.value) >
                              $signed(st.uu_thr));
    assign cond[`AL_SLOPE] = st.slope_hit;
    // back at or below threshold minus deadband releases a latch
    assign release_ok[`AL_UPPER] = ($signed(value_ext) <=
                                    $signed(upper_rel));
    assign release_ok[`AL_UU]    = ($signed(value_ext) <=
                                    $signed(uu_rel));
    assign release_ok[`AL_SLOPE] = 1'b0;

    // change per millisecond against limit, multiply instead of divide
    assign delta      = {i_scan.fixed_value[31], i_scan.fixed_value}
                      - {st.value[31], st.value};
    assign delta_mag  = delta[32] ? (33'h000000000 - delta) : delta;
    assign dt         = st.ms_count - st.scan_stamp;
    // two scans inside the same millisecond count as one millisecond
    assign dt_eff     = (dt == '0) ? `STAMP_ONE : dt;
    assign slope_room = st.slope_lim * dt_eff;
    assign slope_over = delta_mag > {2'b00, slope_room};

    // ---------------------------------------------------------------
    // calibration helpers and bus decode
    // ---------------------------------------------------------------
    assign cal_variant = st.ctrl[`CTRL_CAL_VARIANT];
    // success is refused while any reference is bad or missing
    assign pass_ok  = i_cal.pass & st.low_ok & st.high_ok
                    & ~st.low_bad & ~st.high_bad;
    assign bus_take = i_hsel & i_htrans[1] & i_hready;

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    function automatic logic [31:0] rd_mux(
        input ain_status_pkg::state_t s,
        input logic [7:0]             a,
        input logic [9:0]             stat
    );
        logic [31:0] r;
        r = '0;
        unique case (a)
            `REG_CTRL:       r = {24'h000000, s.ctrl};
            `REG_UNLATCH:    r = {29'h00000000, s.unlatch};
            `REG_UPPER_THR:  r = s.upper_thr;
            `REG_UU_THR:     r = s.uu_thr;
            `REG_DEADBAND:   r = s.deadband;
            `REG_SLOPE_LIM:  r = {16'h0000, s.slope_lim};
            `REG_STATUS:     r = {22'h000000, stat};
            `REG_DATA:       r = s.data_word;
            `REG_SCAN_STAMP: r = {17'h00000, s.scan_stamp};
            `REG_NOW_STAMP:  r = {17'h00000, s.ms_count};
            default:         r = '0; // unmapped reads as zero
        endcase
        return r;
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;

        // free-running stamp, wraps past its maximum
        next_st.div = ms_tick ? '0 : st.div + `DIV_W'(1);
        if (ms_tick) begin
            next_st.ms_count = (st.ms_count == `STAMP_MAX) ? '0
                             : st.ms_count + `STAMP_ONE;
        end

        // scan: capture float word, fixed value and the stamp
        if (i_scan.scan) begin
            next_st.data_word  = i_scan.real_word;
            next_st.value      = i_scan.fixed_value;
            next_st.scan_stamp = st.ms_count;
            next_st.have_prev  = 1'b1;
            next_st.slope_hit  = st.have_prev & slope_over;
        end

        // alarm flags: a live condition beats any release
        next_st.unlatch_prev = st.unlatch;
        for (int i = 0; i < `NALARM; i++) begin
            if (!alarm_act[i]) begin
                next_st.flags[i] = 1'b0;
            end else if (cond[i]) begin
                next_st.flags[i] = 1'b1;
            end else if (!latch_on[i]) begin
                next_st.flags[i] = 1'b0;
            end else if (unl_edge[i] || release_ok[i]) begin
                next_st.flags[i] = 1'b0;
            end
        end

        // success flag lives only while the connection is open
        if (!i_conn_open) begin
            next_st.done_ok = 1'b0;
        end

        // calibration sequencer
        unique case (st.cal_state)
            ain_status_pkg::CAL_IDLE: begin
                if (i_cal.start) begin
                    next_st.cal_state = ain_status_pkg::CAL_RUN;
                    next_st.low_ok    = 1'b0;
                    next_st.low_bad   = 1'b0;
                    next_st.high_ok   = 1'b0;
                    next_st.high_bad  = 1'b0;
                    next_st.done_ok   = 1'b0;
                end
            end
            ain_status_pkg::CAL_RUN: begin
                if (i_cal.low_sampled) begin
                    next_st.low_ok  = i_cal.low_valid;
                    next_st.low_bad = ~i_cal.low_valid;
                end
                if (i_cal.high_sampled) begin
                    next_st.high_ok  = i_cal.high_valid;
                    next_st.high_bad = ~i_cal.high_valid;
                end
                if (i_cal.abort) begin
                    // any abort means the last attempt failed
                    next_st.cal_state   = ain_status_pkg::CAL_IDLE;
                    next_st.cal_failure = 1'b1;
                end else if (pass_ok) begin
                    next_st.cal_state   = ain_status_pkg::CAL_IDLE;
                    next_st.cal_failure = 1'b0;
                    next_st.done_ok     = i_conn_open;
                end
            end
        endcase

        // bus data phase: write lands one cycle after the address
        if (st.bus_act && st.bus_write) begin
            unique case (st.bus_addr)
                `REG_CTRL:      next_st.ctrl      = i_hwdata[7:0];
                `REG_UNLATCH:   next_st.unlatch   = i_hwdata[`NALARM-1:0];
                `REG_UPPER_THR: next_st.upper_thr = i_hwdata;
                `REG_UU_THR:    next_st.uu_thr    = i_hwdata;
                `REG_DEADBAND:  next_st.deadband  = i_hwdata;
                `REG_SLOPE_LIM: next_st.slope_lim = i_hwdata[15:0];
                default:        ; // read-only or unmapped: ignored
            endcase
        end

        // bus address phase; read data sampled from the next state (the status word from
        // the current one) so a read right behind a write already sees the new value
        next_st.bus_act   = bus_take;
        next_st.bus_write = i_hwrite;
        next_st.bus_addr  = {i_haddr[7:2], 2'b00};
        if (bus_take && !i_hwrite) begin
            next_st.hrdata = rd_mux(next_st, {i_haddr[7:2], 2'b00},
                                    o_status);
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // power-up reset clears every flag, the failure flag included
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            st           <= '0;
            st.ctrl      <= `CTRL_RST;
            st.upper_thr <= `THR_RST;
            st.uu_thr    <= `THR_RST;
            st.deadband  <= `DEADBAND_RST;
            st.slope_lim <= `SLOPE_LIM_RST;
            st.cal_state <= ain_status_pkg::CAL_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // the plain data variant hides reference and success flags
    always_comb begin
        o_status = '0;
        o_status.upper_limit_alarm_flag       = st.flags[`AL_UPPER];
        o_status.upper_upper_limit_alarm_flag = st.flags[`AL_UU];
        o_status.slope_alarm_flag             = st.flags[`AL_SLOPE];
        o_status.cal_failure_flag             = st.cal_failure;
        o_status.calibrating_flag             =
            (st.cal_state == ain_status_pkg::CAL_RUN);
        o_status.low_reference_ok_flag        = cal_variant & st.low_ok;
        o_status.low_reference_invalid_flag   = cal_variant & st.low_bad;
        o_status.high_reference_ok_flag       = cal_variant & st.high_ok;
        o_status.high_reference_invalid_flag  = cal_variant & st.high_bad;
        o_status.cal_done_ok_flag             =
            cal_variant & st.done_ok;
    end

    assign o_data      = st.data_word;
    assign o_stamp     = st.scan_stamp;
    assign o_hrdata    = st.hrdata;
    assign o_hreadyout = 1'b1; // zero wait states
    assign o_hresp     = 1'b0; // always OKAY

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_upper_set: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (alarm_act[`AL_UPPER] && cond[`AL_UPPER]) |=>
            o_status.upper_limit_alarm_flag)
        else $error("upper alarm missed");

    a_uu_set: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (alarm_act[`AL_UU] && cond[`AL_UU]) |=>
            o_status.upper_upper_limit_alarm_flag)
        else $error("upper-upper alarm missed");

    a_latch_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (alarm_act[`AL_UPPER] && latch_on[`AL_UPPER]
         && st.flags[`AL_UPPER] && !unl_edge[`AL_UPPER]
         && !release_ok[`AL_UPPER]) |=> st.flags[`AL_UPPER])
        else $error("latched upper alarm dropped");

    a_slope_hold: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (alarm_act[`AL_SLOPE] && latch_on[`AL_SLOPE]
         && st.flags[`AL_SLOPE] && !unl_edge[`AL_SLOPE])
            |=> st.flags[`AL_SLOPE])
        else $error("latched slope alarm dropped");

    a_unlatch_clear: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (alarm_act[`AL_UU] && !cond[`AL_UU] && $rose(st.unlatch[`AL_UU]))
            |=> !st.flags[`AL_UU])
        else $error("unlatch did not release");

    a_alarms_off: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        st.ctrl[`CTRL_ALARMS_OFF] |=> (st.flags == '0))
        else $error("alarm raised while disabled");

    a_abort_fault: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (st.cal_state == ain_status_pkg::CAL_RUN && i_cal.abort) |=>
            (o_status.cal_failure_flag && !o_status.calibrating_flag))
        else $error("abort did not flag failure");

    a_cal_start: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (st.cal_state == ain_status_pkg::CAL_IDLE && i_cal.start) |=>
            o_status.calibrating_flag && !o_status.cal_done_ok_flag)
        else $error("calibrating flag not raised");

    a_stamp_wrap: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (ms_tick && st.ms_count == `STAMP_MAX) |=> (st.ms_count == '0))
        else $error("stamp did not wrap");

    a_scan_stamp: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        i_scan.scan |=> (o_stamp == $past(st.ms_count)
                         && o_data == $past(i_scan.real_word)))
        else $error("scan stamp not captured");

    a_variant_hide: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !cal_variant |-> (o_status[9:5] == 5'h00))
        else $error("calibration flags shown in plain variant");

endmodule

/* analog_input_channel_status_cfg.svh */
// constants for the analog input channel status block
`ifndef ANALOG_INPUT_CHANNEL_STATUS_CFG_SVH
`define ANALOG_INPUT_CHANNEL_STATUS_CFG_SVH

// ---------------------------------------------------------------
// register byte offsets (word aligned)
// ---------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_UNLATCH     8'h04
`define REG_UPPER_THR   8'h08
`define REG_UU_THR      8'h0C
`define REG_DEADBAND    8'h10
`define REG_SLOPE_LIM   8'h14
`define REG_STATUS      8'h18
`define REG_DATA        8'h1C
`define REG_SCAN_STAMP  8'h20
`define REG_NOW_STAMP   8'h24

// ---------------------------------------------------------------
// control fields and alarm indices
// ---------------------------------------------------------------
`define NALARM          3
`define AL_UPPER        0
`define AL_UU           1
`define AL_SLOPE        2
`define CTRL_EN_LSB     0
`define CTRL_LATCH_LSB  3
`define CTRL_ALARMS_OFF 6
`define CTRL_CAL_VARIANT 7

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define CTRL_RST        8'h00
`define THR_RST         32'h7FFFFFFF
`define DEADBAND_RST    32'h00000000
`define SLOPE_LIM_RST   16'hFFFF
`define STAMP_W         15
`define STAMP_MAX       15'h7FFF
`define STAMP_ONE       15'h0001
`define MS_PERIOD_NS    1000000
`define CLK_PERIOD_NS   25
`define CYC_PER_MS      (`MS_PERIOD_NS / `CLK_PERIOD_NS)
`define DIV_W           16

`endif

/* ain_status_pkg.sv */
// types shared by the analog input channel status block
`include "analog_input_channel_status_cfg.svh"

package ain_status_pkg;

    // calibration sequencer, one-hot
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_RUN  = 2'b10
    } cal_state_t;

    // channel status word, bit 0 first from the bottom
    typedef struct packed {
        logic cal_done_ok_flag;
        logic high_reference_invalid_flag;
        logic high_reference_ok_flag;
        logic low_reference_invalid_flag;
        logic low_reference_ok_flag;
        logic calibrating_flag;
        logic cal_failure_flag;
        logic slope_alarm_flag;
        logic upper_upper_limit_alarm_flag;
        logic upper_limit_alarm_flag;
    } chan_status_t;

    // one channel scan from the converter path
    typedef struct packed {
        logic        scan;
        logic [31:0] real_word;
        logic [31:0] fixed_value;
    } scan_in_t;

    // events from the calibration engine
    typedef struct packed {
        logic start;
        logic low_sampled;
        logic low_valid;
        logic high_sampled;
        logic high_valid;
        logic abort;
        logic pass;
    } cal_evt_t;

    // whole state of the block
    typedef struct packed {
        logic [7:0]              ctrl;
        logic [`NALARM-1:0]      unlatch;
        logic [`NALARM-1:0]      unlatch_prev;
        logic [31:0]             upper_thr;
        logic [31:0]             uu_thr;
        logic [31:0]             deadband;
        logic [15:0]             slope_lim;
        logic [`NALARM-1:0]      flags;
        logic                    slope_hit;
        cal_state_t              cal_state;
        logic                    cal_failure;
        logic                    low_ok;
        logic                    low_bad;
        logic                    high_ok;
        logic                    high_bad;
        logic                    done_ok;
        logic [31:0]             data_word;
        logic [31:0]             value;
        logic                    have_prev;
        logic [`STAMP_W-1:0]     scan_stamp;
        logic [`DIV_W-1:0]       div;
        logic [`STAMP_W-1:0]     ms_count;
        logic                    bus_act;
        logic                    bus_write;
        logic [7:0]              bus_addr;
        logic [31:0]             hrdata;
    } state_t;

endpackage

/* conn_keeper.sv */
// controller side model that opens and holds the module connection
`timescale 1ns/1ps
module conn_keeper (
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    input  wire logic i_want,
    output logic      o_open
);
    // connection opens one cycle after the request, drops with reset
    always_ff @(posedge i_clk_sys) begin
        o_open <= i_rstn & i_want;
    end
endmodule

/* testbench.sv */
// self-checking bench for the analog input channel status block
`timescale 1ns/1ps
`include "analog_input_channel_status_cfg.svh"
module testbench;
    logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, rdy, conn;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    ain_status_pkg::scan_in_t scn = '0;
    ain_status_pkg::cal_evt_t cal = '0;
    ain_status_pkg::chan_status_t st;
    logic [31:0] dat;
    logic [14:0] stp;
    logic resp;
    logic want = 1'b1;
    int errors = 0, cmp_count = 0, cyc = 0;
    // one stamp tick per clock, so the stamp wrap fits in a short run
    localparam int MSC = 1;
    always #12.5 clk = ~clk;
    // reference count of edges since reset release
    always @(posedge clk) cyc <= rstn ? cyc + 1 : 0;
    conn_keeper pk (.i_clk_sys(clk), .i_rstn(rstn), .i_want(want),
                    .o_open(conn));
    analog_input_channel_status #(.MS_CYCLES(MSC)) uut (
        .i_clk_sys(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy),
        .o_hresp(resp), .o_hrdata(hrdata), .i_scan(scn), .i_cal(cal),
        .i_conn_open(conn), .o_status(st), .o_data(dat), .o_stamp(stp));
    // ---------------------------------------------------------------
    // bus, stimulus and compare helpers
    // ---------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        @(posedge clk); while (rdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0; hwdata <= d;
        @(posedge clk); while (rdy !== 1'b1) @(posedge clk);
        rd = hrdata; // read data taken at the closing edge
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    // one scan pulse, then settle; the stamp is held against the model
    task automatic scan(input logic [31:0] v);
        int c;
        scn <= '{scan: 1'b1, real_word: v, fixed_value: v};
        @(posedge clk);
        scn.scan <= 1'b0;
        c = cyc;
        repeat (3) @(posedge clk);
        chk({17'h0, stp}, {17'h0, 15'(c / MSC)}, "stamp");
    endtask
    task automatic cev(input logic [6:0] e);
        cal <= e; @(posedge clk); cal <= '0; repeat (2) @(posedge clk);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    // reset, then reset values and the bus response
    task automatic t_reset;
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({22'h0, st}, 32'h0, "status after reset");
        bus(0, `REG_UPPER_THR, 32'h0);
        chk(rd, `THR_RST, "threshold reset");
        chk({31'h0, resp}, 32'h0, "response not okay");
    endtask
    // thresholds first, so the alarms-off check can really trip
    task automatic t_limits;
        bus(1, `REG_UPPER_THR, 32'h64);
        bus(1, `REG_UU_THR, 32'h96);
        bus(1, `REG_CTRL, 32'h47);
        scan(32'h000000C8);
        chk({22'h0, st}, 32'h0, "alarms off still flag");
        bus(1, `REG_CTRL, 32'h07);
        scan(32'h000000C8);
        chk({22'h0, st}, 32'h3, "both limits");
        chk(dat, 32'h000000C8, "data word");
        scan(32'h00000078);
        chk({22'h0, st}, 32'h1, "upper only");
    endtask
    task automatic t_latch;
        bus(1, `REG_DEADBAND, 32'h32);
        bus(1, `REG_CTRL, 32'h0F);
        scan(32'h000000C8);
        scan(32'h0000005A);
        chk({22'h0, st}, 32'h1, "latched upper lost");
        bus(1, `REG_UNLATCH, 32'h1);
        repeat (2) @(posedge clk);
        chk({22'h0, st}, 32'h0, "unlatch ignored");
        scan(32'h000000C8);
        scan(32'h00000028);
        chk({22'h0, st}, 32'h0, "deadband release");
    endtask
    // slope alarm latched beside a latched upper-upper alarm
    task automatic t_slope;
        bus(1, `REG_SLOPE_LIM, 32'h1);
        bus(1, `REG_CTRL, 32'h36);
        scan(32'h00007530);
        chk({22'h0, st}, 32'h6, "slope and upper-upper");
        bus(1, `REG_SLOPE_LIM, 32'hFFFF);
        scan(32'h0000007D);
        chk({22'h0, st}, 32'h6, "latched slope lost");
        bus(1, `REG_UNLATCH, 32'h6);
        repeat (2) @(posedge clk);
        chk({22'h0, st}, 32'h0, "unlatch ignored");
    endtask
    task automatic t_cal;
        bus(1, `REG_CTRL, 32'h80);
        cev(7'h40);
        chk({22'h0, st}, 32'h10, "calibrating");
        cev(7'h20);
        chk({22'h0, st}, 32'h50, "low ref invalid");
        cev(7'h02);
        chk({22'h0, st}, 32'h48, "abort failure");
        bus(0, `REG_STATUS, 32'h0);
        chk(rd, 32'h48, "status read");
    endtask
    // refused pass, good references, success, then the connection drops
    task automatic t_success;
        cev(7'h40);
        chk({22'h0, st}, 32'h18, "failure kept");
        cev(7'h20);
        cev(7'h01);
        chk({22'h0, st}, 32'h58, "pass with bad ref");
        cev(7'h30);
        chk({22'h0, st}, 32'h38, "low ref ok");
        cev(7'h0C);
        chk({22'h0, st}, 32'hB8, "high ref ok");
        cev(7'h01);
        chk({22'h0, st}, 32'h2A0, "success");
        bus(1, `REG_CTRL, 32'h00);
        @(posedge clk);
        chk({22'h0, st}, 32'h0, "plain variant");
        bus(1, `REG_CTRL, 32'h80);
        @(posedge clk);
        chk({22'h0, st}, 32'h2A0, "success kept");
        want <= 1'b0;
        repeat (3) @(posedge clk);
        chk({22'h0, st}, 32'hA0, "success after close");
        want <= 1'b1;
        cev(7'h40);
        cev(7'h30);
        cev(7'h08);
        cev(7'h02);
        chk({22'h0, st}, 32'h128, "bad high ref abort");
    endtask
    // run past the stamp maximum, then read the live counter
    task automatic t_wrap;
        repeat (32768) @(posedge clk);
        bus(0, `REG_NOW_STAMP, 32'h0);
        chk(rd, {17'h0, 15'(cyc / MSC)}, "wrap");
    endtask
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        t_reset;
        t_limits;
        t_latch;
        t_slope;
        t_cal;
        t_success;
        t_wrap;
        t_reset;
        wrap_up;
    end
    // a hang counts as a failure
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        wrap_up;
    end
endmodule
